//--- rtl/adc_pkg.sv
// constants and state codes shared by the converter control files
package adc_pkg;
	localparam int CLK_PERIOD_NS = 100;
	localparam int CONV_TIME_NS = 3800;
	localparam int SLEEP_CONV_TIME_NS = 9800;
	localparam int WAKE_TIME_NS = SLEEP_CONV_TIME_NS - CONV_TIME_NS;
	// worst case from a pin edge to a registered output: three sampling flops plus the edge register
	localparam int SYNC_DELAY_CYCLES = 4;
	// longest times round down; the sync delay is taken out so the pin-to-pin figure holds
	localparam int CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS - SYNC_DELAY_CYCLES;
	localparam int WAKE_CYCLES = WAKE_TIME_NS / CLK_PERIOD_NS;
	localparam int SCLK_MAX_HZ = 15000000;
	localparam int READ_QUIET_NS = 300;
	localparam int RESULT_BITS = 12;
	localparam int LEAD_ZEROS = 4;
	localparam int WORD_BITS = LEAD_ZEROS + RESULT_BITS;
	localparam int CNT_W = 7;
	localparam int EDGE_CNT_W = 4;
	localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYCLES - 1);
	localparam logic [CNT_W-1:0] WAKE_LAST = CNT_W'(WAKE_CYCLES - 1);
	localparam logic [CNT_W-1:0] CNT_ZERO = 7'h00;
	localparam logic [EDGE_CNT_W-1:0] EDGE_ZERO = 4'h0;
	localparam logic [EDGE_CNT_W-1:0] EDGE_LAST = 4'hF;
	localparam logic [LEAD_ZEROS-1:0] LEAD_PAD = 4'h0;
	localparam logic [RESULT_BITS-1:0] CODE_RESET = 12'h000;
	localparam logic [WORD_BITS-1:0] WORD_RESET = 16'h0000;
	localparam logic SCLK_IDLE = 1'b0;
	localparam logic CONVERT_START_N_IDLE = 1'b1;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_CONV = 4'b0010,
		ST_SLEEP = 4'b0100,
		ST_WAKE = 4'b1000
	} conv_state_t;
endpackage : adc_pkg

//--- rtl/stream_if.sv
// valid/ready word stream between the conversion core, the buffer and the serial shifter
`timescale 1ns/100ps
interface stream_if #(parameter int WIDTH = 16) ();
	logic valid;
	logic ready;
	logic [WIDTH-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : stream_if

//--- rtl/result_buffer.sv
// small flip-flop fifo holding finished result words until the serial port takes them
`timescale 1ns/100ps
module result_buffer
	import adc_pkg::*;
#(
	parameter int WIDTH = 16,
	parameter int DEPTH = 2
)
(
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	stream_if.snk fill,
	stream_if.src drain
);
	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [PTR_W:0] COUNT_FULL = (PTR_W + 1)'(DEPTH);
	localparam logic [PTR_W:0] COUNT_EMPTY = '0;

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || $bits(fill.data) != WIDTH)
	begin : g_bad_cfg
		$error("result_buffer needs a power-of-two depth of two or more and a matching width");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PTR_W-1:0] wr_ptr;
	logic [PTR_W-1:0] rd_ptr;
	logic [PTR_W:0] count;
	logic push;
	logic pop;

	assign fill.ready = (count != COUNT_FULL);
	assign drain.valid = (count != COUNT_EMPTY);
	assign drain.data = mem[rd_ptr];
	assign push = fill.valid && fill.ready;
	assign pop = drain.valid && drain.ready;

	always_ff @(posedge clk_sys_i)
	begin
		if (push)
		begin
			mem[wr_ptr] <= fill.data;
		end
	end

	// power-of-two depth lets the pointers wrap on their own
	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end
		else
		begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
			count <= COUNT_EMPTY;
		else if (push && !pop)
			count <= count + 1'b1;
		else if (pop && !push)
			count <= count - 1'b1;
	end

	chk_buffer_count_bound: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		count <= COUNT_FULL) else $error("buffer count above depth");
	cov_buffer_full: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) count == COUNT_FULL);
endmodule : result_buffer

//--- rtl/adc_convert_serial_readout.sv
// conversion control, auto power-down and serial result readout of a 12-bit sar converter
// Function
// RULE_01: next result bit driven on serial clock fall
// RULE_02: host may capture on that same fall
// RULE_03: host leaves serial clock low after readout
// RULE_04: sixteen bits: four zeros then twelve result
// RULE_05: sixteenth fall: hold bit, then release output
// RULE_06: two's complement bipolar, straight binary unipolar
// RULE_07: busy rises on start fall, drops at end
// RULE_08: start fall holds sample, begins conversion
// RULE_09: start low at end: sleep; rise wakes
// RULE_10: host keeps serial clock within maximum rate
// RULE_11: conversion within 3.8 or 9.8 microseconds; with a full buffer the end stalls and busy stays high until a word is read
// RULE_12: wake timed from rise, conversion from fall
// RULE_13: host avoids reading during or before conversion
// RULE_14: result bits msb first, lsb in slot sixteen
`timescale 1ns/100ps
module adc_convert_serial_readout
	import adc_pkg::*;
#(
	parameter bit BIPOLAR = 1'b1,
	parameter int BUF_DEPTH = 2
)
(
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic serial_clock_i,
	input wire logic convert_start_n_i,
	input wire logic [RESULT_BITS-1:0] analog_code_i,
	output logic serial_result_out_o,
	output logic serial_result_oe_n_o,
	output logic busy_o,
	output logic track_hold_o,
	output logic power_down_o
);
	if (BUF_DEPTH != 2)
	begin : g_bad_depth
		$error("the readout path is built for a two-entry buffer");
	end

	function automatic logic filter_level(input logic s2, input logic s3, input logic prev);
		return (s2 == s3) ? s2 : prev;
	endfunction : filter_level

	// quantizer delivers offset binary; bipolar parts flip the msb
	function automatic logic [RESULT_BITS-1:0] encode_code(input logic [RESULT_BITS-1:0] code);
		return BIPOLAR ? {~code[RESULT_BITS-1], code[RESULT_BITS-2:0]} : code;
	endfunction : encode_code

	logic sclk_meta;
	logic sclk_s2;
	logic sclk_s3;
	logic sclk_lvl;
	logic cs_meta;
	logic cs_s2;
	logic cs_s3;
	logic cs_lvl;
	logic next_sclk_lvl;
	logic next_cs_lvl;
	logic sclk_fall;
	logic cs_fall;
	logic cs_rise;

	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
		begin
			sclk_meta <= SCLK_IDLE;
			sclk_s2 <= SCLK_IDLE;
			sclk_s3 <= SCLK_IDLE;
			sclk_lvl <= SCLK_IDLE;
			cs_meta <= CONVERT_START_N_IDLE;
			cs_s2 <= CONVERT_START_N_IDLE;
			cs_s3 <= CONVERT_START_N_IDLE;
			cs_lvl <= CONVERT_START_N_IDLE;
		end
		else
		begin
			sclk_meta <= serial_clock_i;
			sclk_s2 <= sclk_meta;
			sclk_s3 <= sclk_s2;
			sclk_lvl <= next_sclk_lvl;
			cs_meta <= convert_start_n_i;
			cs_s2 <= cs_meta;
			cs_s3 <= cs_s2;
			cs_lvl <= next_cs_lvl;
		end
	end

	assign next_sclk_lvl = filter_level(sclk_s2, sclk_s3, sclk_lvl);
	assign next_cs_lvl = filter_level(cs_s2, cs_s3, cs_lvl);
	assign sclk_fall = sclk_lvl && !next_sclk_lvl;
	assign cs_fall = cs_lvl && !next_cs_lvl;
	assign cs_rise = !cs_lvl && next_cs_lvl;

	stream_if #(.WIDTH(WORD_BITS)) res_fill ();
	stream_if #(.WIDTH(WORD_BITS)) res_drain ();

	result_buffer #(.WIDTH(WORD_BITS), .DEPTH(BUF_DEPTH)) u_buffer (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.fill(res_fill),
		.drain(res_drain)
	);

	conv_state_t state;
	logic [CNT_W-1:0] cnt;
	logic pending;
	logic [RESULT_BITS-1:0] held_code;
	logic accept_fall;
	logic conv_done;
	logic wake_end;

	// a start edge during a running conversion is ignored
	assign accept_fall = cs_fall && (state != ST_CONV);
	// a full buffer stalls the end of conversion so no word is lost
	assign conv_done = (state == ST_CONV) && (cnt == CNT_ZERO) && res_fill.ready;
	assign wake_end = (state == ST_WAKE) && (cnt == CNT_ZERO);
	assign res_fill.valid = (state == ST_CONV) && (cnt == CNT_ZERO);
	assign res_fill.data = {LEAD_PAD, encode_code(held_code)}; // [RULE_04] [RULE_06]

	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
		begin
			state <= ST_IDLE;
			cnt <= CNT_ZERO;
		end
		else
		begin
			unique case (state)
				ST_IDLE:
				begin
					if (cs_fall)
					begin
						state <= ST_CONV; // [RULE_08]
						cnt <= CONV_LAST; // [RULE_11]
					end
				end
				ST_CONV:
				begin
					if (cnt != CNT_ZERO)
						cnt <= cnt - 1'b1;
					else if (res_fill.ready)
						state <= cs_lvl ? ST_IDLE : ST_SLEEP; // [RULE_09]
				end
				ST_SLEEP:
				begin
					if (cs_rise)
					begin
						state <= ST_WAKE; // [RULE_09] [RULE_12]
						cnt <= WAKE_LAST;
					end
				end
				ST_WAKE:
				begin
					if (cnt != CNT_ZERO)
						cnt <= cnt - 1'b1;
					else if (pending || cs_fall)
					begin
						state <= ST_CONV; // [RULE_12]
						cnt <= CONV_LAST;
					end
					else
						state <= ST_IDLE;
				end
			endcase
		end
	end

	// a start edge taken during the wake-up waits for the wake-up to finish
	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
			pending <= 1'b0;
		else if (wake_end)
			pending <= 1'b0;
		else if (accept_fall && (state != ST_IDLE))
			pending <= 1'b1;
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
			held_code <= CODE_RESET;
		else if (accept_fall)
			held_code <= analog_code_i; // [RULE_08]
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
		begin
			busy_o <= 1'b0;
			track_hold_o <= 1'b0;
		end
		else if (accept_fall)
		begin
			busy_o <= 1'b1; // [RULE_07]
			track_hold_o <= 1'b1; // [RULE_08]
		end
		else if (conv_done)
		begin
			busy_o <= 1'b0; // [RULE_07]
			track_hold_o <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
			power_down_o <= 1'b0;
		else if (conv_done && !cs_lvl)
			power_down_o <= 1'b1; // [RULE_09]
		else if ((state == ST_SLEEP) && cs_rise)
			power_down_o <= 1'b0; // [RULE_09]
	end

	logic active;
	logic [WORD_BITS-1:0] shift;
	logic [EDGE_CNT_W-1:0] edges;

	assign res_drain.ready = !active;

	// output released after the sixteenth fall; the next buffered word loads one cycle later
	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
		begin
			active <= 1'b0;
			shift <= WORD_RESET;
			edges <= EDGE_ZERO;
			serial_result_out_o <= 1'b0;
			serial_result_oe_n_o <= 1'b1;
		end
		else if (!active)
		begin
			if (res_drain.valid)
			begin
				active <= 1'b1;
				shift <= res_drain.data;
				edges <= EDGE_ZERO;
				serial_result_out_o <= res_drain.data[WORD_BITS-1]; // [RULE_14]
				serial_result_oe_n_o <= 1'b0;
			end
		end
		else if (sclk_fall)
		begin
			if (edges == EDGE_LAST)
			begin
				active <= 1'b0; // [RULE_03]
				serial_result_oe_n_o <= 1'b1; // [RULE_05]
			end
			else
			begin
				shift <= {shift[WORD_BITS-2:0], 1'b0};
				edges <= edges + 1'b1;
				serial_result_out_o <= shift[WORD_BITS-2]; // [RULE_01] [RULE_14]
			end
		end
	end

	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rst_n_i);

	localparam int WAKE_N = WAKE_CYCLES;

	chk_bit_on_fall: assert property (active && sclk_fall && edges != EDGE_LAST |=> // [RULE_01]
		serial_result_out_o == $past(shift[WORD_BITS-2]) && !serial_result_oe_n_o) else $error("bit not advanced");
	chk_lead_zeros: assert property (active && edges < EDGE_CNT_W'(LEAD_ZEROS) |-> // [RULE_04]
		!serial_result_out_o) else $error("leading bit not zero");
	chk_release_last: assert property (active && sclk_fall && edges == EDGE_LAST |=> // [RULE_05]
		serial_result_oe_n_o && !active && $stable(serial_result_out_o)) else $error("output not released");
	chk_result_coding: assert property (res_fill.valid |-> // [RULE_06]
		res_fill.data[RESULT_BITS-1] == (held_code[RESULT_BITS-1] ^ BIPOLAR)) else $error("wrong coding");
	chk_busy_rise: assert property (accept_fall |=> busy_o && track_hold_o) else $error("busy not raised"); // [RULE_07]
	chk_busy_fall: assert property (conv_done |=> !busy_o && state != ST_CONV) else $error("busy not dropped"); // [RULE_07]
	chk_sample_hold: assert property (accept_fall |=> held_code == $past(analog_code_i)) else $error("no hold"); // [RULE_08]
	chk_sleep_entry: assert property (conv_done && !cs_lvl |=> power_down_o && state == ST_SLEEP) // [RULE_09]
		else $error("no power-down");
	chk_wake_up: assert property (state == ST_SLEEP && cs_rise |=> !power_down_o && state == ST_WAKE) // [RULE_09]
		else $error("no wake-up");
	chk_conv_length: assert property (state == ST_IDLE && cs_fall |=> // [RULE_11]
		state == ST_CONV && cnt == CONV_LAST) else $error("conversion length wrong");
	chk_wake_length: assert property ($rose(state == ST_WAKE) |-> ##WAKE_N state != ST_WAKE // [RULE_12]
		) else $error("wake-up length wrong");
	chk_out_msb: assert property (active |-> serial_result_out_o == shift[WORD_BITS-1]) // [RULE_14]
		else $error("output not msb of shifter");

	cov_readout_done: cover property (active && sclk_fall && edges == EDGE_LAST);
	cov_sleep_cycle: cover property (state == ST_SLEEP ##1 state == ST_WAKE);
	cov_wake_convert: cover property (state == ST_WAKE ##1 state == ST_CONV);
	cov_stalled_end: cover property (res_fill.valid && !res_fill.ready);
endmodule : adc_convert_serial_readout

//--- verification/host_model.sv
// host side model: serial clock source and result word capture
`timescale 1ns/100ps
module host_model
(
	input wire logic data_i,
	output logic serial_clock_o
);
	initial serial_clock_o = 1'b0;
	// 800 ns period, far below the port limit
	task automatic read_frame(output logic [15:0] w);
		w = 16'h0000;
		#13;
		repeat (16)
		begin
			#400 serial_clock_o = 1'b1;
			// sample on the very fall that advances the bit
			#400 w = {w[14:0], data_i};
			serial_clock_o = 1'b0;
		end
		// clock parked low once the frame is done
	endtask : read_frame
endmodule : host_model

//--- verification/adc_convert_serial_readout_bench.sv
// self-checking bench for converter control and serial readout
`timescale 1ns/100ps
module adc_convert_serial_readout_bench;
	import adc_pkg::*;
	logic clk_sys_i;
	logic rst_n_i;
	logic sclk;
	logic start_n;
	logic [RESULT_BITS-1:0] code;
	logic out;
	logic oe_n;
	logic busy;
	logic th;
	logic pd;
	logic [15:0] w;
	int err_count = 0;
	int n_tests = 0;
	// a released line shows the inverse of its last bit, never a lucky match
	wire serial_result_out = oe_n ? ~out : out;

	adc_convert_serial_readout #(.BIPOLAR(1'b1), .BUF_DEPTH(2)) uut
	(
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.serial_clock_i(sclk),
		.convert_start_n_i(start_n),
		.analog_code_i(code),
		.serial_result_out_o(out),
		.serial_result_oe_n_o(oe_n),
		.busy_o(busy),
		.track_hold_o(th),
		.power_down_o(pd)
	);

	host_model host
	(
		.data_i(serial_result_out),
		.serial_clock_o(sclk)
	);

	initial
	begin
		clk_sys_i = 1'b0;
		forever #50 clk_sys_i = ~clk_sys_i;
	end

	task automatic report_and_stop;
		if (err_count == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : report_and_stop

	task automatic cmp1(input string n, input logic e, input logic s);
		n_tests++;
		if (s !== e)
		begin
			err_count++;
			$display("[ERR] %s exp %b got %b", n, e, s);
		end
	endtask : cmp1

	task automatic cmpw(input string n, input logic [15:0] e, input logic [15:0] s);
		n_tests++;
		if (s !== e)
		begin
			err_count++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask : cmpw

	task automatic cmpn(input string n, input int e, input int s);
		n_tests++;
		if (s > e)
		begin
			err_count++;
			$display("[ERR] %s exp <= %0d got %0d", n, e, s);
		end
	endtask : cmpn

	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys_i);
	endtask : cyc

	task automatic rd(input logic [11:0] c);
		int t;
		t = 0;
		while (oe_n !== 1'b0 && t < 60)
		begin
			cyc(1);
			t++;
		end
		cmp1("lead_bit", 1'b0, out);
		host.read_frame(w);
		cmpw("word", {LEAD_PAD, ~c[11], c[10:0]}, w);
		t = 0;
		while (oe_n !== 1'b1 && t < 8)
		begin
			cyc(1);
			t++;
		end
		cmpn("release", 6, t);
	endtask : rd

	task automatic convert(input logic [11:0] c, output int t);
		cyc(1);
		code = c;
		start_n = 1'b0;
		t = 0;
		while (busy !== 1'b1 && t < 10)
		begin
			cyc(1);
			t++;
		end
		cmpn("busy_rise", SYNC_DELAY_CYCLES + 2, t);
		cmp1("hold", 1'b1, th);
		// input moves after the start edge; the word must keep the held sample
		code = ~c;
		cyc(1);
		start_n = 1'b1;
		cyc(4);
		start_n = 1'b0;
		cyc(4);
		start_n = 1'b1;
		t += 9;
		while (busy === 1'b1 && t < 60)
		begin
			cyc(1);
			t++;
		end
		cmp1("awake", 1'b0, pd);
	endtask : convert

	task automatic fill_drain;
		logic [11:0] codes[4] = '{12'h000, 12'hFFF, 12'h800, 12'h5A3};
		logic [11:0] q[$];
		logic stalled;
		int t;
		stalled = 1'b0;
		for (int i = 0; i < 4 && !stalled; i++)
		begin
			q.push_back(codes[i]);
			convert(codes[i], t);
			if (busy === 1'b1)
				stalled = 1'b1;
			else
				cmpn("conv_time", CONV_TIME_NS / CLK_PERIOD_NS, t);
		end
		cmp1("stall", 1'b1, stalled);
		while (q.size() > 0)
			rd(q.pop_front());
		cyc(60);
		cmp1("no_extra", 1'b1, oe_n);
	endtask : fill_drain

	task automatic sleep_wake;
		int t;
		code = 12'h7FF;
		start_n = 1'b0;
		cyc(45);
		cmp1("asleep", 1'b1, pd);
		cmp1("busy_end", 1'b0, busy);
		start_n = 1'b1;
		cyc(4);
		code = 12'h123;
		start_n = 1'b0;
		cyc(4);
		cmp1("waking", 1'b0, pd);
		cmp1("busy_latched", 1'b1, busy);
		start_n = 1'b1;
		t = 8;
		while (busy === 1'b1 && t < 120)
		begin
			cyc(1);
			t++;
		end
		cmpn("wake_conv", SLEEP_CONV_TIME_NS / CLK_PERIOD_NS, t);
		cmp1("awake_end", 1'b0, pd);
		// reads only once busy is low
		rd(12'h7FF);
		rd(12'h123);
	endtask : sleep_wake

	// six frames of 13 us plus conversions stay far under 2 ms
	initial
	begin
		#2_000_000;
		err_count++;
		report_and_stop;
	end

	initial
	begin
		rst_n_i = 1'b0;
		start_n = CONVERT_START_N_IDLE;
		code = CODE_RESET;
		repeat (16) @(negedge clk_sys_i);
		rst_n_i = 1'b1;
		cyc(4);
		fill_drain;
		sleep_wake;
		report_and_stop;
	end
endmodule : adc_convert_serial_readout_bench
